/* File: core/ddu_regs.vh */
// Notes on behaviour
// R1 - trigger select 0: latch transparent, core follows each data write, enable ignored.
// R2 - trigger select 1: latch loads after software writes the data register.
// R3 - select 2 loads on compare-one rising edge; select 3 on compare-two.
// R4 - select above zero latches only while conversion enable is set.
// R5 - straight binary: full scale 0fff at 12 bits, 0ff at 8 bits.
// R6 - two's complement: 0800 gives zero, 0000 mid-scale, 07ff full scale.
// R7 - two's complement becomes offset binary by inverting the sign bit.
// R8 - calibration start bit launches calibration and clears itself when done.
// R9 - software sets buffer power first and waits for calibration to end.
// R10 - grouped converters update in the same cycle, never split.
// R11 - only converter zero's group bit enables grouping.
// R12 - when grouped, converter one's trigger select drives both converters.
// R13 - grouped use needs both selects above zero and both enables set.
// R14 - grouped update waits until both data registers written since last update.
// R15 - grouped, selects above zero, either enable clear: neither converter updates.
// R16 - load-done flag sets on each latch load with select above zero only.
// R17 - flag with local and global enable raises request; software clears flag.
// R18 - request shares a vector with dma; software checks both flags.
// R19 - software must not feed data faster than output settling allows.
// R20 - resolution select 0 is 12-bit, 1 is 8-bit.
// R21 - at 8-bit resolution data bits 11 to 8 are ignored.
// R22 - data format select 0 straight binary, 1 two's complement.
`ifndef DDU_REGS_VH
`define DDU_REGS_VH
// register indices; the bus byte address is four times the index
`define DDU_CTL0_IDX    12'h1c0
`define DDU_CTL1_IDX    12'h1c2
`define DDU_DAT0_IDX    12'h1c8
`define DDU_DAT1_IDX    12'h1ca
`define DDU_CTL0_ADDR   (`DDU_CTL0_IDX << 2)
`define DDU_CTL1_ADDR   (`DDU_CTL1_IDX << 2)
`define DDU_DAT0_ADDR   (`DDU_DAT0_IDX << 2)
`define DDU_DAT1_ADDR   (`DDU_DAT1_IDX << 2)
`define DDU_ADDR_W      12
`define DDU_CTL_RST     16'h0000
`define DDU_DAT_RST     12'h000
`define DDU_CTL_MASK    16'hfffb
`define DDU_B_GRP       0
`define DDU_B_ENC       1
`define DDU_B_IFG       2
`define DDU_B_IE        3
`define DDU_B_DF        4
`define DDU_B_CAL       9
`define DDU_B_LSEL_LO   10
`define DDU_B_RES       12
`define DDU_LSEL_XPAR   2'h0
`define DDU_LSEL_WRITE  2'h1
`define DDU_LSEL_CMP1   2'h2
`define DDU_LSEL_CMP2   2'h3
`define DDU_CAL_CYCLES  16'h0100
`define DDU_CAL_IDLE    16'h0000
`define DDU_CAL_STEP    16'h0001
`define DDU_SIGN12      11
`define DDU_SIGN8       7
`endif

/* File: core/ddu_top.v */
`timescale 1ns/1ps
`include "ddu_regs.vh"
module ddu_top #(
  parameter [15:0] CAL_CYCLES = `DDU_CAL_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        compare_one_output_i,
  input  wire        compare_two_output_i,
  input  wire        global_irq_enable_i,
  output wire        irq_o,
  output reg  [11:0] core_code_zero_o,
  output reg  [11:0] core_code_one_o,
  output reg  [1:0]  cal_busy_o
);

  // register state
  reg  [15:0] ctl [0:1];
  reg  [11:0] dat [0:1];
  reg  [11:0] latch [0:1];
  reg  [1:0]  wr_seen;
  reg         cmp1_q;
  reg         cmp2_q;
  reg  [15:0] cal_cnt [0:1];
  reg  [31:0] rdata;

  wire        acc = psel_i & penable_i;
  wire        wr  = acc & pwrite_i;
  wire        hit_c0 = (paddr_i == `DDU_CTL0_ADDR);
  wire        hit_c1 = (paddr_i == `DDU_CTL1_ADDR);
  wire        hit_d0 = (paddr_i == `DDU_DAT0_ADDR);
  wire        hit_d1 = (paddr_i == `DDU_DAT1_ADDR);
  wire        mapped = hit_c0 | hit_c1 | hit_d0 | hit_d1;
  wire [1:0]  wr_ctl = {wr & hit_c1, wr & hit_c0};
  wire [1:0]  wr_dat = {wr & hit_d1, wr & hit_d0};

  // zero-wait slave; unmapped addresses answer with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o  = rdata;

  // edge detect of timer compare outputs
  // history resets low like an idle timer line, so reset makes no false edge
  wire cmp1_rise = compare_one_output_i & ~cmp1_q;
  wire cmp2_rise = compare_two_output_i & ~cmp2_q;

  // grouping uses converter zero's bit only; converter one's is ignored
  wire grouped = ctl[0][`DDU_B_GRP]; // [R11]
  wire [1:0] sel_own0 = ctl[0][`DDU_B_LSEL_LO+1:`DDU_B_LSEL_LO];
  wire [1:0] sel1     = ctl[1][`DDU_B_LSEL_LO+1:`DDU_B_LSEL_LO];
  wire       grp_enc  = ctl[0][`DDU_B_ENC] & ctl[1][`DDU_B_ENC];
  wire       grp_sel_ok = (sel_own0 != `DDU_LSEL_XPAR) && (sel1 != `DDU_LSEL_XPAR);
  // after this cycle's writes, have both data registers been written?
  wire [1:0] seen_now = wr_seen | wr_dat;

  // per-converter trigger decision
  function trig_of;
    input [1:0] sel;
    input       wrote;
    input       c1r;
    input       c2r;
    begin
      case (sel)
        `DDU_LSEL_WRITE: begin
          trig_of = wrote;  // [R2]
        end
        `DDU_LSEL_CMP1: begin
          trig_of = c1r;    // [R3]
        end
        `DDU_LSEL_CMP2: begin
          trig_of = c2r;    // [R3]
        end
        default: begin
          trig_of = 1'b0;
        end
      endcase
    end
  endfunction

  // grouped: converter one's select is the common trigger
  wire grp_trig = trig_of(sel1, |wr_dat, cmp1_rise, cmp2_rise); // [R12]
  // group is armed only with both selects above zero and both enables set
  wire grp_armed = grouped & grp_sel_ok & grp_enc; // [R15]
  // single update decision for both, so the pair never splits
  wire grp_load = grp_armed & grp_trig & (&seen_now); // [R10] [R14]

  reg  [1:0] load;
  reg  [1:0] xpar;
  integer k;
  // load strobes: grouped path or each converter on its own select
  always @* begin
    for (k = 0; k < 2; k = k + 1) begin
      xpar[k] = 1'b0;
      load[k] = 1'b0;
      if (grouped) begin
        load[k] = grp_load;
      end else if (ctl[k][`DDU_B_LSEL_LO+1:`DDU_B_LSEL_LO] == `DDU_LSEL_XPAR) begin
        xpar[k] = 1'b1; // [R1]
      end else begin
        load[k] = ctl[k][`DDU_B_ENC] & // [R4]
                  trig_of(ctl[k][`DDU_B_LSEL_LO+1:`DDU_B_LSEL_LO],
                          wr_dat[k], cmp1_rise, cmp2_rise);
      end
    end
  end

  // core code: mask at 8 bits, sign-flip for two's complement
  function [11:0] to_core;
    input [11:0] d;
    input        res8;
    input        twos;
    reg   [11:0] m;
    begin
      if (res8) begin
        m = {4'h0, d[7:0]};                      // [R20] [R21] [R5]
      end else begin
        m = d;                                   // [R5]
      end
      if (twos && res8) begin
        m[`DDU_SIGN8] = ~m[`DDU_SIGN8];          // [R7] [R6] [R22]
      end else if (twos) begin
        m[`DDU_SIGN12] = ~m[`DDU_SIGN12];        // [R7] [R6] [R22]
      end
      to_core = m;
    end
  endfunction

  // registers, latches, calibration, per converter
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : conv
      // a word written in this very cycle must reach the latch, not the stale one
      wire [11:0] src      = wr_dat[g] ? pwdata_i[11:0] : dat[g];
      // countdown has run out while the start bit still stands
      wire        cal_done = ctl[g][`DDU_B_CAL] && (cal_cnt[g] == `DDU_CAL_IDLE);
      // start taken only from idle, so rewriting the bit cannot stretch a run
      wire        cal_go   = wr_ctl[g] && pwdata_i[`DDU_B_CAL] && !ctl[g][`DDU_B_CAL];
      reg  [15:0] next_ctl;
      reg  [15:0] next_cal_cnt;
      reg  [11:0] next_latch;

      // control word: software write first, else calibration clear; flag set on top
      always @* begin
        next_ctl = ctl[g];
        if (wr_ctl[g]) begin
          next_ctl = pwdata_i[15:0];
        end else if (cal_done) begin
          next_ctl[`DDU_B_CAL] = 1'b0; // [R8]
        end
        // hardware set wins over a software clear in the same cycle
        if (load[g]) begin
          next_ctl[`DDU_B_IFG] = 1'b1; // [R16] [R17]
        end
      end

      // calibration countdown; a fresh start outranks the running count
      always @* begin
        next_cal_cnt = cal_cnt[g];
        if (cal_go) begin
          next_cal_cnt = CAL_CYCLES; // [R8]
        end else if (cal_cnt[g] != `DDU_CAL_IDLE) begin
          next_cal_cnt = cal_cnt[g] - `DDU_CAL_STEP;
        end
      end

      // latch: transparent path first, then triggered loads
      always @* begin
        next_latch = latch[g];
        if (xpar[g] && wr_dat[g]) begin
          next_latch = pwdata_i[11:0]; // [R1]
        end else if (load[g]) begin
          next_latch = src; // [R2] [R3] [R4]
        end
      end

      // control, countdown and latch of one converter
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          ctl[g]     <= `DDU_CTL_RST;
          latch[g]   <= `DDU_DAT_RST;
          cal_cnt[g] <= `DDU_CAL_IDLE;
        end else begin
          ctl[g]     <= next_ctl;
          latch[g]   <= next_latch;
          cal_cnt[g] <= next_cal_cnt;
        end
      end

      // data word; bits 15-12 are dropped and read back as zero
      always @(posedge clk_i) begin
        if (!rst_b_i) begin
          dat[g] <= `DDU_DAT_RST;
        end else if (wr_dat[g]) begin
          dat[g] <= pwdata_i[11:0];
        end
      end
    end
  endgenerate

  reg [31:0] next_rdata;
  reg [1:0]  next_seen;

  // read word picked in the setup cycle, so it stands through the access cycle
  always @* begin
    next_rdata = rdata;
    if (psel_i && !penable_i && !pwrite_i) begin
      case (1'b1)
        hit_c0: begin
          next_rdata = {16'h0000, ctl[0]};
        end
        hit_c1: begin
          next_rdata = {16'h0000, ctl[1]};
        end
        hit_d0: begin
          next_rdata = {20'h00000, dat[0]};
        end
        hit_d1: begin
          next_rdata = {20'h00000, dat[1]};
        end
        default: begin
          next_rdata = 32'h0000_0000; // holes read as zero
        end
      endcase
    end
  end

  // group write tracking; a group load starts a fresh round
  always @* begin
    next_seen = seen_now;
    if (grp_load) begin
      next_seen = 2'b00; // [R14]
    end
  end

  // write tracking for the group
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_seen <= 2'b00;
    end else begin
      wr_seen <= next_seen;
    end
  end

  // timer edge history
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cmp1_q <= 1'b0;
      cmp2_q <= 1'b0;
    end else begin
      cmp1_q <= compare_one_output_i;
      cmp2_q <= compare_two_output_i;
    end
  end

  // codes to the analog core; format applies to the stored word
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      core_code_zero_o <= `DDU_DAT_RST;
      core_code_one_o  <= `DDU_DAT_RST;
    end else begin
      core_code_zero_o <= to_core(latch[0], ctl[0][`DDU_B_RES], ctl[0][`DDU_B_DF]);
      core_code_one_o  <= to_core(latch[1], ctl[1][`DDU_B_RES], ctl[1][`DDU_B_DF]);
    end
  end

  // calibration status
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      cal_busy_o <= 2'b00;
    end else begin
      cal_busy_o <= {ctl[1][`DDU_B_CAL], ctl[0][`DDU_B_CAL]}; // [R8]
    end
  end

  // read data register
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // per-converter request before the global gate
  wire irq_zero = ctl[0][`DDU_B_IFG] & ctl[0][`DDU_B_IE]; // [R17]
  wire irq_one  = ctl[1][`DDU_B_IFG] & ctl[1][`DDU_B_IE]; // [R17]
  // one line to the shared vector; software tells dma apart by its own flag
  assign irq_o = global_irq_enable_i & (irq_zero | irq_one); // [R17] [R18]

endmodule

/* File: tb/ddu_top_chk.sv */
`timescale 1ns/1ps
module ddu_top_chk #(parameter [15:0] CAL_CYCLES = 16'h0100) (
  input wire        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_o,
  input wire        compare_one_output_i, compare_two_output_i, global_irq_enable_i,
  input wire [11:0] paddr_i, core_code_zero_o, core_code_one_o,
  input wire [31:0] pwdata_i, prdata_o,
  input wire [1:0]  cal_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire      acc = psel_i && penable_i;
  wire      hit = paddr_i[11:6] == 6'h1c && !paddr_i[4] && paddr_i[2:0] == 3'h0;
  reg [2:0] quiet;
  // cycles since a bus write or timer activity; codes may only move shortly after
  always @(posedge clk_i)
    if (!rst_b_i || acc && pwrite_i || compare_one_output_i || compare_two_output_i) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  property p_rdy; acc |-> pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_err; acc && !hit |-> pslverr_o && (pwrite_i || prdata_o == 32'h0); endproperty
  a_err: assert property (p_err) else $error("hole not refused");
  property p_ok; pslverr_o |-> acc && !hit; endproperty
  a_ok: assert property (p_ok) else $error("stray error");
  property p_irq; irq_o |-> global_irq_enable_i; endproperty
  a_irq: assert property (p_irq) else $error("masked request");
  property p_code; $changed(core_code_zero_o) || $changed(core_code_one_o) |-> quiet < 3'h5;
  endproperty
  a_code: assert property (p_code) else $error("code moved alone");
  property p_calr; $rose(cal_busy_o[0]) |->
    $past(acc && pwrite_i && paddr_i == 12'h700 && pwdata_i[9], 2); endproperty
  a_calr: assert property (p_calr) else $error("calibration unasked");
  property p_calf; $rose(cal_busy_o[0]) |-> ##[1:1000] !cal_busy_o[0]; endproperty
  a_calf: assert property (p_calf) else $error("calibration stuck");
  property p_dat; acc && !pwrite_i && hit && paddr_i[5] |-> prdata_o[31:12] == 20'h0; endproperty
  a_dat: assert property (p_dat) else $error("data top bits set");
endmodule
bind ddu_top ddu_top_chk #(.CAL_CYCLES(CAL_CYCLES)) i_ddu_top_chk (.*);

/* File: tb/tb_ddu_top.sv */
`timescale 1ns/1ps
`define CK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h not %h", $time, a, b); end end
module tb_ddu_top;
  reg         clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, er;
  reg         compare_one_output_i = 1'b0, compare_two_output_i = 1'b0, global_irq_enable_i = 1'b0;
  reg  [11:0] paddr_i = 12'h0, d, e;
  reg  [31:0] pwdata_i = 32'h0, rd;
  wire [31:0] prdata_o;
  wire [11:0] core_code_zero_o, core_code_one_o;
  wire [1:0]  cal_busy_o;
  wire        pready_o, pslverr_o, irq_o;
  integer     err_count = 0, tests_run = 0, i, n;
  // byte addresses: register index times four
  localparam [11:0] C0 = 12'h700, C1 = 12'h708, D0 = 12'h720, D1 = 12'h728;
  ddu_top #(.CAL_CYCLES(16'h0004)) i_ddu_top (.*);
  // 10 mhz clock
  always #50 clk_i = ~clk_i;
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // setup cycle, then access held until ready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] v);
    begin
      @(posedge clk_i) {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, v};
      @(posedge clk_i) penable_i <= 1'b1;
      n = 0;
      @(posedge clk_i) while (pready_o !== 1'b1 && n < 16) begin @(posedge clk_i); n++; end
      rd = prdata_o;
      er = pslverr_o;
      {psel_i, penable_i} <= 2'h0;
      if (n == 16) begin err_count++; wrap_up; end
    end
  endtask
  task wr(input [11:0] a, input [31:0] v); apb(1'b1, a, v); endtask
  task tk(input integer k); repeat (k) @(posedge clk_i); endtask
  // one-cycle pulse on a timer line, then room for edge detect and latch
  task pulse(input k);
    begin
      @(posedge clk_i) {compare_two_output_i, compare_one_output_i} <= {k, !k};
      @(posedge clk_i) {compare_two_output_i, compare_one_output_i} <= 2'h0;
      tk(4);
    end
  endtask
  function [11:0] ex(input [11:0] v, input f);
    ex = f ? v ^ 12'h800 : v;
  endfunction
  initial begin
    n = $urandom(32'h70ab);
    tk(20);
    rst_b_i <= 1'b1;
    for (i = 0; i < 5; i++) begin
      apb(1'b0, C0 + {i[1], i[2], i[0], 3'h0}, 32'h0);
      `CK(rd, 32'h0)
      `CK(er, i == 4)
    end
    wr(C0 + 12'h010, 32'hffff);
    `CK(er, 1'b1)
    $display("reset test done");
    // transparent latch, both formats, enable clear; corner words on passes 1 and 3
    for (i = 0; i < 16; i++) begin
      d = i == 1 ? 12'h800 : i == 3 ? 12'h7ff : 12'($urandom);
      wr(C0, {27'h0, i[0], 4'h0});
      wr(D0, {20'hfffff, d});
      tk(2);
      `CK(core_code_zero_o, ex(d, i[0]))
    end
    apb(1'b0, D0, 32'h0);
    `CK(rd, {20'h0, d})
    wr(C0, 32'h1000);
    tk(2);
    e = core_code_zero_o;
    wr(D0, {20'h0, d ^ 12'hf80});
    wr(C0, 32'h1010);
    tk(2);
    `CK(core_code_zero_o, e)
    $display("format test done");
    global_irq_enable_i <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(C0, 32'h408 + i * 2);
      tk(2);
      e = core_code_zero_o;
      d = 12'($urandom);
      wr(D0, {20'h0, d});
      tk(2);
      `CK(core_code_zero_o, i ? d : e)
      `CK(irq_o, i == 1)
    end
    global_irq_enable_i <= 1'b0;
    tk(1);
    `CK(irq_o, 1'b0)
    wr(C0, 32'h040a);
    global_irq_enable_i <= 1'b1;
    tk(1);
    `CK(irq_o, 1'b0)
    $display("irq test done");
    // timer triggers; the other line must not load
    for (i = 2; i < 4; i++) begin
      wr(C0, i * 1024 + 2);
      e = core_code_zero_o;
      d = 12'($urandom);
      wr(D0, {20'h0, d});
      pulse(i == 2);
      `CK(core_code_zero_o, e)
      pulse(i == 3);
      `CK(core_code_zero_o, d)
    end
    $display("timer test done");
    wr(C0, 32'h0040);
    wr(C0, 32'h0240);
    tk(2);
    `CK(cal_busy_o, 2'h1)
    tk(8);
    apb(1'b0, C0, 32'h0);
    `CK(rd[9], 1'b0)
    $display("calibration test done");
    // grouped pair: both words needed, one shared update
    wr(C1, 32'h0402);
    wr(C0, 32'h0803);
    e = core_code_zero_o;
    d = 12'($urandom);
    wr(D0, {20'h0, d});
    tk(3);
    `CK(core_code_zero_o, e)
    wr(D1, {20'h0, ~d});
    for (i = 0; i < 4; i++) begin
      `CK(core_code_zero_o == d, core_code_one_o == ~d)
      tk(1);
    end
    `CK(core_code_one_o, ~d)
    wr(C1, 32'h0400);
    wr(D0, 32'h0);
    wr(D1, 32'h0);
    tk(3);
    `CK(core_code_zero_o, d)
    $display("group test done");
    wrap_up;
  end
endmodule
